/* design/video_window_two_selector.sv */
// window-two selector: vertical/field/frame/horizontal window of a stream
// assumes the upstream stream and line_std_525 come from sys_clk logic
//
// Contract
// - report active-flag delay after reference trailing edge
// - vertical start gives first active line
// - input line count spans active window lines
// - clamp start plus count to field length
// - decimation keeps programmed frames per 3000
// - field flags select odd, even, both, none
// - drop lines down to output line count
// - horizontal start crops pixels on the left
// - window length counted in scaled pixels
// - scale full active line to active pixels
//
// The Avalon-MM slave port was decided locally.
module video_window_two_selector
  import video_window_two_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // avalon-mm register slave
  input wire logic [video_window_two_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [video_window_two_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [video_window_two_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // line standard: high for 525-line, low for 625-line
  input wire logic line_std_525,
  // pixel streams
  input wire video_window_two_pkg::video_in_t vin,
  output video_window_two_pkg::video_out_t vout
);
  import video_window_two_pkg::*;

  // the counters and comparators below are sized from the package
  if (PIX_W < 2 || LINE_W < 2 || REG_W <= PIX_W) begin : g_chk
    $error("window field widths cannot be served");
  end

  // register bus

  bus_state_t bus_r;               // idle or answering
  bus_state_t bus_nxt;
  logic [DATA_W-1:0] rdata_r;      // read data, loaded on acceptance
  logic [DATA_W-1:0] rdata_nxt;
  logic [IDX_W-1:0] reg_idx;       // word index of the access
  logic req;                       // read or write pending
  logic wr_fire;                   // write takes effect this edge
  logic rd_take;                   // read data captured this edge

  assign reg_idx = avs_address[ADDR_W-1:2];
  assign req = avs_read | avs_write;
  // one wait cycle, then the answer; the master holds until then
  assign avs_waitrequest = req & (bus_r == BUS_IDLE);
  assign wr_fire = avs_write & (bus_r == BUS_DONE);
  assign rd_take = avs_read & (bus_r == BUS_IDLE);
  assign avs_readdata = rdata_r;

  // per-register address decodes for writes and the read mux
  logic hit_vstart;
  logic hit_vin;
  logic hit_vout;
  logic hit_hstart;
  logic hit_hlen;
  logic hit_npix;
  logic hit_dec;
  logic hit_act;

  assign hit_vstart = (reg_idx == IDX_VSTART);
  assign hit_vin = (reg_idx == IDX_VLINES_IN);
  assign hit_vout = (reg_idx == IDX_VLINES_OUT);
  assign hit_hstart = (reg_idx == IDX_HSTART);
  assign hit_hlen = (reg_idx == IDX_HLEN);
  assign hit_npix = (reg_idx == IDX_NPIX);
  assign hit_dec = (reg_idx == IDX_DEC_FRAMES);
  assign hit_act = (reg_idx == IDX_ACT_FLAG);

  // write data merged by byte lanes 0 and 1 (upper lanes hold nothing)
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old_v,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [REG_W-1:0] v;
    v = old_v;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[REG_W-1:8] = wd[REG_W-1:8];
    end
    return v;
  endfunction

  // window parameters, all twelve bits kept; reserved bits are never
  // looked at, so a nonzero write there does no harm
  logic [REG_W-1:0] vstart_r;
  logic [REG_W-1:0] vlin_r;
  logic [REG_W-1:0] vlout_r;
  logic [REG_W-1:0] hstart_r;
  logic [REG_W-1:0] hlen_r;
  logic [REG_W-1:0] npix_r;
  logic [REG_W-1:0] dec_r;         // frames kept per interval

  // parameter writes take effect at once, also mid-field
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vstart_r <= RST_VSTART;
      vlin_r <= RST_VLINES_IN;
      vlout_r <= RST_VLINES_OUT;
      hstart_r <= RST_HSTART;
      hlen_r <= RST_HLEN;
      npix_r <= RST_NPIX;
      dec_r <= RST_DEC_FRAMES;
    end else if (wr_fire) begin
      if (hit_vstart) vstart_r <= merge(vstart_r, avs_writedata,
                                        avs_byteenable);
      if (hit_vin) vlin_r <= merge(vlin_r, avs_writedata, avs_byteenable);
      if (hit_vout) vlout_r <= merge(vlout_r, avs_writedata,
                                     avs_byteenable);
      if (hit_hstart) hstart_r <= merge(hstart_r, avs_writedata,
                                        avs_byteenable);
      if (hit_hlen) hlen_r <= merge(hlen_r, avs_writedata, avs_byteenable);
      if (hit_npix) npix_r <= merge(npix_r, avs_writedata, avs_byteenable);
      if (hit_dec) dec_r <= merge(dec_r, avs_writedata, avs_byteenable);
    end
  end

  // fields in use
  logic [LINE_W-1:0] vbeg;
  logic [LINE_W-1:0] vlinei;
  logic [LINE_W-1:0] vlineo;
  logic tdec_en;
  logic [1:0] fdis;
  logic [PIX_W-1:0] hbeg;
  logic [PIX_W-1:0] hlen;
  logic [PIX_W-1:0] npix;

  assign vbeg = vstart_r[LINE_W-1:0];
  assign vlinei = vlin_r[LINE_W-1:0];
  assign vlineo = vlout_r[LINE_W-1:0];
  assign tdec_en = vlin_r[TDEC_BIT];
  assign fdis = vlin_r[FDIS_LSB +: 2];
  assign hbeg = hstart_r[PIX_W-1:0];
  assign hlen = hlen_r[PIX_W-1:0];
  assign npix = npix_r[PIX_W-1:0];

  // measured delay, shown in the read-only position register
  logic [PIX_W-1:0] act_delay_r;

  // read mux: only the position and the decimation count read back,
  // write-only and unmapped words read as zero
  always_comb begin
    rdata_nxt = '0;
    if (hit_act) begin
      rdata_nxt[ACT_DELAY_LSB +: PIX_W] = act_delay_r;
    end else if (hit_dec) begin
      rdata_nxt[REG_W-1:0] = dec_r;
    end
  end

  // bus sequencer: accept, then answer one cycle later
  always_comb begin
    case (bus_r)
      BUS_IDLE: bus_nxt = req ? BUS_DONE : BUS_IDLE;
      BUS_DONE: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  // bus state and read data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_r <= BUS_IDLE;
      rdata_r <= '0;
    end else begin
      bus_r <= bus_nxt;
      if (rd_take) rdata_r <= rdata_nxt;
    end
  end

  // stream timing

  logic ref_q;                     // reference of the previous cycle
  logic ref_rise;
  logic ref_fall;
  logic pix_in;                    // an input pixel of the active line

  assign ref_rise = vin.horizontal_reference & ~ref_q;
  assign ref_fall = ~vin.horizontal_reference & ref_q;
  assign pix_in = vin.valid & vin.horizontal_reference;

  // vertical window

  logic [LINE_W-1:0] line_r;       // line number within the field
  logic [LINE_W-1:0] line_cur;     // number of the line now running
  logic [LINE_W-1:0] max_lines;
  logic [LINE_W-1:0] room;         // lines left from the start line
  logic [LINE_W-1:0] vlinei_eff;   // input span after correction
  logic [LINE_W:0] vend;           // first line past the window
  logic in_vwin;

  assign line_cur = ref_rise ? LINE_W'(line_r + 1'b1) : line_r;
  assign max_lines = line_std_525 ? LINES_525 : LINES_625;
  assign room = (vbeg >= max_lines) ? '0 : LINE_W'(max_lines - vbeg);
  // a span running past the field end is cut to the field
  assign vlinei_eff = (vlinei > room) ? room : vlinei;
  assign vend = {1'b0, vbeg} + {1'b0, vlinei_eff};
  // window is [start, start + span) in field line numbers
  assign in_vwin = ({1'b0, line_cur} >= {1'b0, vbeg}) &&
                   ({1'b0, line_cur} < vend);

  // line counter, restarts at each field
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      line_r <= '0;
    end else begin
      ref_q <= vin.horizontal_reference;
      if (vin.field_start) begin
        line_r <= '0;
      end else if (ref_rise && line_r != '1) begin
        line_r <= line_cur;
      end
    end
  end

  // uniform line dropping from the span down to the output count;
  // output count above the span just keeps every line
  logic line_keep;
  keep_ratio #(.W(LINE_W)) u_line_drop (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(vin.field_start),
    .step(ref_rise & in_vwin),
    .num(vlineo),
    .den(vlinei_eff),
    .keep(line_keep)
  );

  // field selection
  logic field_ok;
  always_comb begin
    case (fdis)
      FIELD_BOTH: field_ok = 1'b1;
      FIELD_EVEN_ONLY: field_ok = ~vin.field_odd;
      FIELD_ODD_ONLY: field_ok = vin.field_odd;
      FIELD_OFF: field_ok = 1'b0;
      default: field_ok = 1'b0;
    endcase
  end

  // temporal decimation: a frame begins with its odd field, and both
  // fields of a frame share one decision
  logic frame_step;
  logic frame_pick;
  logic frame_keep;
  assign frame_step = vin.field_start & vin.field_odd;
  keep_ratio #(.W(REG_W)) u_frame_drop (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(1'b0),
    .step(frame_step),
    .num(dec_r),
    .den(FRAME_INTERVAL),
    .keep(frame_pick)
  );
  // with decimation off every frame passes
  assign frame_keep = ~tdec_en | frame_pick;

  // horizontal scaling and window

  logic [PIX_W-1:0] pin_r;         // input pixels seen in this line
  logic [PIX_W-1:0] prev_len_r;    // input pixels of the last line
  logic [PIX_W-1:0] sc_r;          // scaled pixels kept so far
  logic [PIX_W-1:0] sc_cur;        // scaled index of this pixel
  logic [PIX_W:0] hend;
  logic pix_keep;
  logic in_hwin;

  // scaling drops pixels evenly so the line shrinks to npix; it only
  // shrinks, and the ratio follows the previous line's length, so the
  // first line after a length change may come out uneven
  keep_ratio #(.W(PIX_W)) u_pix_drop (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(ref_rise),
    .step(pix_in),
    .num(npix),
    .den(prev_len_r),
    .keep(pix_keep)
  );

  assign sc_cur = ref_rise ? '0 : sc_r;
  assign hend = {1'b0, hbeg} + {1'b0, hlen};
  // crop hbeg on the left, pass hlen, never past npix
  assign in_hwin = ({1'b0, sc_cur} >= {1'b0, hbeg}) &&
                   ({1'b0, sc_cur} < hend) &&
                   (sc_cur < npix);

  // pixel counters, cleared at the start of each line
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_r <= '0;
      prev_len_r <= '0;
      sc_r <= '0;
    end else begin
      if (ref_rise) begin
        pin_r <= pix_in ? PIX_W'(1) : '0;
      end else if (pix_in && pin_r != '1) begin
        pin_r <= pin_r + 1'b1;
      end
      if (ref_fall) prev_len_r <= pin_r;
      if (pix_in && pix_keep && sc_cur != '1) begin
        sc_r <= sc_cur + 1'b1;
      end else if (ref_rise) begin
        sc_r <= '0;
      end
    end
  end

  // pass decision and output stage

  logic go;
  assign go = pix_in & pix_keep & in_hwin & in_vwin & line_keep &
              field_ok & frame_keep;

  // output registers: data only changes on a passed pixel
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vout.valid <= 1'b0;
      vout.active <= 1'b0;
      vout.data <= '0;
    end else begin
      vout.valid <= go;
      vout.active <= go;
      if (go) vout.data <= vin.data;
    end
  end

  // active-flag position: cycles from the reference trailing edge to
  // the first passed pixel of the next line; saturates at all ones
  logic [PIX_W-1:0] dcnt_r;
  logic armed_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dcnt_r <= '0;
      armed_r <= 1'b0;
      act_delay_r <= '0;
    end else if (ref_fall) begin
      dcnt_r <= '0;
      armed_r <= 1'b1;
    end else if (armed_r) begin
      if (dcnt_r != '1) dcnt_r <= dcnt_r + 1'b1;
      if (go) begin
        act_delay_r <= dcnt_r;
        armed_r <= 1'b0;
      end
    end
  end

endmodule // video_window_two_selector

/* common/video_window_two_pkg.sv */
// constants, register map and stream carriers of the window-two selector
// assumes one 250 mhz clock and an avalon-mm slave with 32-bit data
package video_window_two_pkg;

  // widths of the window fields
  localparam int PIX_W = 11;
  localparam int LINE_W = 9;
  localparam int REG_W = 12;
  localparam int VID_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ACT_FLAG = 10'h11f;
  localparam logic [IDX_W-1:0] IDX_VSTART = 10'h12a;
  localparam logic [IDX_W-1:0] IDX_VLINES_IN = 10'h12b;
  localparam logic [IDX_W-1:0] IDX_VLINES_OUT = 10'h12c;
  localparam logic [IDX_W-1:0] IDX_HSTART = 10'h12d;
  localparam logic [IDX_W-1:0] IDX_HLEN = 10'h12e;
  localparam logic [IDX_W-1:0] IDX_NPIX = 10'h12f;
  localparam logic [IDX_W-1:0] IDX_DEC_FRAMES = 10'h157;

  // reset values
  localparam logic [REG_W-1:0] RST_VSTART = 12'h011;
  localparam logic [REG_W-1:0] RST_VLINES_IN = 12'h1f4;
  localparam logic [REG_W-1:0] RST_VLINES_OUT = 12'h0f0;
  localparam logic [REG_W-1:0] RST_HSTART = 12'h000;
  localparam logic [REG_W-1:0] RST_HLEN = 12'h280;
  localparam logic [REG_W-1:0] RST_NPIX = 12'h280;
  localparam logic [REG_W-1:0] RST_DEC_FRAMES = 12'hbb8;

  // field positions
  localparam int TDEC_BIT = 9;
  localparam int FDIS_LSB = 10;
  localparam int ACT_DELAY_LSB = 1;

  // field disable codes
  localparam logic [1:0] FIELD_BOTH = 2'h0;
  localparam logic [1:0] FIELD_EVEN_ONLY = 2'h1;
  localparam logic [1:0] FIELD_ODD_ONLY = 2'h2;
  localparam logic [1:0] FIELD_OFF = 2'h3;

  // temporal decimation interval in frames
  localparam logic [REG_W-1:0] FRAME_INTERVAL = 12'hbb8;

  // lines per field of the two line standards
  localparam logic [LINE_W-1:0] LINES_625 = 9'h138;
  localparam logic [LINE_W-1:0] LINES_525 = 9'h106;

  // upstream pixel stream, same clock as the block
  typedef struct packed {
    logic valid;
    logic horizontal_reference;
    logic field_start;
    logic field_odd;
    logic [VID_W-1:0] data;
  } video_in_t;

  // windowed pixel stream towards the capture logic
  typedef struct packed {
    logic valid;
    logic active;
    logic [VID_W-1:0] data;
  } video_out_t;

  // register bus answer sequencing
  typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;

endpackage

/* design/keep_ratio.sv */
// keeps num of every den events, spread evenly (bresenham style)
// assumes restart is a one-cycle pulse on sys_clk; step may stay high, one event per cycle
module keep_ratio #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // events
  input wire logic restart,
  input wire logic step,
  // ratio
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  // decision for the current event, held until the next
  output logic keep
);

  logic [W-1:0] acc_r;      // running error term, always below den
  logic [W-1:0] acc_nxt;
  logic keep_r;             // decision of the last event
  logic [W-1:0] acc_base;   // restart clears before the step adds
  logic [W-1:0] num_eff;    // no interpolation: never keep more than all
  logic [W:0] sum;
  logic hit;

  assign acc_base = restart ? '0 : acc_r;
  assign num_eff = (num > den) ? den : num;
  assign sum = {1'b0, acc_base} + {1'b0, num_eff};
  assign hit = (sum >= {1'b0, den});
  assign acc_nxt = hit ? W'(sum - {1'b0, den}) : W'(sum);
  // combinational so the event cycle itself already sees its decision
  assign keep = step ? hit : keep_r;

  // error term and held decision
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      acc_r <= '0;
      keep_r <= 1'b0;
    end else if (step) begin
      acc_r <= acc_nxt;
      keep_r <= hit;
    end else if (restart) begin
      acc_r <= '0;
    end
  end

endmodule // keep_ratio

/* verif/video_window_two_asserts.sv */
// concurrent checks on the ports of the window-two selector
// assumes one sys_clk domain and the synchronous active-low nrst
module video_window_two_asserts
  import video_window_two_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // streams
  input wire video_window_two_pkg::video_in_t vin,
  input wire video_window_two_pkg::video_out_t vout
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] fdis_r; // shadow of the field flags
  logic odd_r; // parity of the current field
  wire req = avs_read || avs_write;
  wire fl_wr = avs_write && !avs_waitrequest && avs_byteenable[1]
    && avs_address == {IDX_VLINES_IN, 2'h0};
  // window shut for this field: flags against parity
  wire blocked = fdis_r == FIELD_OFF
    || (fdis_r == FIELD_ODD_ONLY && !odd_r)
    || (fdis_r == FIELD_EVEN_ONLY && odd_r);
  // shadow follows accepted writes only, as the slave does
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fdis_r <= 2'h0;
      odd_r <= 1'b0;
    end else begin
      if (fl_wr) fdis_r <= avs_writedata[11:10];
      if (vin.field_start) odd_r <= vin.field_odd;
    end
  end
  act_flag_a: assert property (vout.active == vout.valid)
    else $error("active flag differs from valid");
  pix_cause_a: assert property (
    vout.valid |-> $past(vin.valid && vin.horizontal_reference))
    else $error("output pixel without input pixel");
  pix_data_a: assert property (
    vout.valid |-> vout.data == $past(vin.data))
    else $error("output data not the passed pixel");
  data_hold_a: assert property (!vout.valid |-> $stable(vout.data))
    else $error("data moved without a pixel");
  field_off_a: assert property (
    blocked && $past(blocked) |-> !vout.valid)
    else $error("pixel in a disabled field");
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  rd_zero_a: assert property (avs_read && !avs_waitrequest
    && avs_address != 12'h47c && avs_address != 12'h55c |-> avs_readdata == '0)
    else $error("write-only or unmapped read not zero");
  delay_fmt_a: assert property (avs_read && !avs_waitrequest
    && avs_address == 12'h47c
    |-> avs_readdata[31:12] == '0 && !avs_readdata[0])
    else $error("delay readback outside bits 11:1");
endmodule // video_window_two_asserts

/* verif/cap_model.sv */
// capture side model: counts lines of one field and pixels of its last line
// assumes pixel data carries the line number in its upper byte
module cap_model
  import video_window_two_pkg::*;
(
  // clock, reset and per-field clear
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clr,
  // windowed stream; capture never stalls
  input wire video_window_two_pkg::video_out_t vout,
  // results
  output int n_lines,
  output int n_last,
  output logic [15:0] first_data
);
  logic [7:0] last_ln; // line tag of the previous pixel
  logic seen; // a pixel arrived this field
  // a new line tag starts a line; gaps inside a line come from scaling
  always_ff @(posedge sys_clk) begin
    if (!nrst || clr) begin
      n_lines <= 0;
      n_last <= 0;
      seen <= 1'b0;
      first_data <= '0;
      last_ln <= '0;
    end else if (vout.valid) begin
      if (!seen) first_data <= vout.data;
      seen <= 1'b1;
      last_ln <= vout.data[15:8];
      if (!seen || vout.data[15:8] != last_ln) begin
        n_lines <= n_lines + 1;
        n_last <= 1;
      end else begin
        n_last <= n_last + 1;
      end
    end
  end
endmodule // cap_model

/* verif/tb_top.sv */
// testbench of the window-two selector: register bus and field stimulus
// assumes an avalon-mm slave; 525-line standard except in the second half of the clamp test
module tb_top
  import video_window_two_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int G = 8; // blank cycles before each line
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf; // full-word writes only
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic line_std_525 = 1'b1; // 262 lines per field
  video_in_t vin = '0;
  video_out_t vout;
  logic clr = 1'b0;
  int n_lines, n_last, fails, cmp_count;
  logic [15:0] first_data;
  logic [31:0] q;
  video_window_two_selector DUT (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .line_std_525(line_std_525), .vin(vin), .vout(vout));
  cap_model cap (.sys_clk(sys_clk), .nrst(nrst), .clr(clr), .vout(vout),
    .n_lines(n_lines), .n_last(n_last), .first_data(first_data));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'h0};
  endfunction
  // reserved bits stay zero and start lines stay legal
  task automatic cfg(input logic [11:0] vs, li, lo, hs, hl, np);
    bus(1'b1, ba(IDX_VSTART), {20'h0, vs});
    bus(1'b1, ba(IDX_VLINES_IN), {20'h0, li});
    bus(1'b1, ba(IDX_VLINES_OUT), {20'h0, lo});
    bus(1'b1, ba(IDX_HSTART), {20'h0, hs});
    bus(1'b1, ba(IDX_HLEN), {20'h0, hl});
    bus(1'b1, ba(IDX_NPIX), {20'h0, np});
  endtask
  // one field of nl lines, 40 pixels each, data = line and pixel number
  task automatic field(input logic odd, input int nl);
    @(posedge sys_clk);
    clr <= 1'b1;
    vin.field_start <= 1'b1;
    vin.field_odd <= odd;
    @(posedge sys_clk);
    clr <= 1'b0;
    vin.field_start <= 1'b0;
    for (int l = 1; l <= nl; l++) begin
      repeat (G) begin
        @(posedge sys_clk);
        vin.horizontal_reference <= 1'b0;
        vin.valid <= 1'b0;
      end
      for (int p = 0; p < 40; p++) begin
        @(posedge sys_clk);
        vin.horizontal_reference <= 1'b1;
        vin.valid <= 1'b1;
        vin.data <= {l[7:0], p[7:0]};
      end
    end
    @(posedge sys_clk);
    vin.horizontal_reference <= 1'b0;
    vin.valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_regs();
    bus(1'b0, ba(IDX_DEC_FRAMES), '0);
    chk(q, 32'h0000_0bb8);
    bus(1'b0, ba(IDX_VSTART), '0);
    chk(q, 32'h0); // write-only place reads zero
    bus(1'b0, 12'h400, '0);
    chk(q, 32'h0); // unmapped place reads zero
  endtask
  task automatic t_window();
    cfg(12'd10, 12'd20, 12'd20, 12'd4, 12'd8, 12'd40);
    field(1'b1, 40);
    chk(n_lines, 20);
    chk(n_last, 8);
    chk(first_data, {8'd10, 8'd4});
    // first kept pixel sits hbeg pixels after a G-cycle blank
    bus(1'b0, ba(IDX_ACT_FLAG), '0);
    chk(q[11:1] >= G + 2 && q[11:1] <= G + 5, 1);
  endtask
  task automatic t_drop();
    cfg(12'd10, 12'd20, 12'd10, 12'd0, 12'd32, 12'd32);
    field(1'b1, 40);
    chk(n_lines, 10);
    chk(n_last, 32);
  endtask
  task automatic t_fields();
    int e;
    for (int f = 0; f < 4; f++) begin
      for (int o = 0; o < 2; o++) begin
        cfg(12'd10, {f[1:0], 10'd10}, 12'd10, 12'd0, 12'd40, 12'd40);
        field(o[0], 25);
        e = (f == 0 || (f == 2 && o == 1) || (f == 1 && o == 0)) ? 10 : 0;
        chk(n_lines, e);
      end
    end
  endtask
  task automatic t_clamp();
    // 250 + 100 passes the 262-line field; only 12 lines fit
    cfg(12'd250, 12'd100, 12'd100, 12'd0, 12'd40, 12'd40);
    field(1'b1, 270);
    chk(n_lines, 12);
    // 305 + 100 passes the 312-line field; only 7 lines fit
    line_std_525 <= 1'b0;
    cfg(12'h131, 12'h064, 12'h064, 12'h000, 12'h028, 12'h028);
    field(1'b1, 315);
    chk(n_lines, 7);
    line_std_525 <= 1'b1;
  endtask
  task automatic t_decim();
    int e;
    bus(1'b1, ba(IDX_DEC_FRAMES), 32'h0);
    bus(1'b0, ba(IDX_DEC_FRAMES), '0);
    chk(q, 32'h0);
    cfg(12'd10, 12'h20a, 12'd10, 12'd0, 12'd40, 12'd40);
    field(1'b1, 25);
    chk(n_lines, 0);
    cfg(12'd10, 12'h00a, 12'd10, 12'd0, 12'd40, 12'd40);
    field(1'b1, 25);
    chk(n_lines, 10);
    // half of the interval kept: exactly one of two frames passes
    bus(1'b1, ba(IDX_DEC_FRAMES), 32'h0000_05dc);
    cfg(12'd10, 12'h20a, 12'd10, 12'd0, 12'd40, 12'd40);
    field(1'b1, 25);
    e = n_lines;
    field(1'b1, 25);
    chk(e + n_lines, 10);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_window();
    t_drop();
    t_fields();
    t_clamp();
    t_decim();
    summarize();
  end
  // watchdog: the run needs about 47k cycles, the limit is 80k
  initial begin
    #320000;
    fails++;
    summarize();
  end
endmodule // tb_top
bind video_window_two_selector video_window_two_asserts u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .vin(vin), .vout(vout));
